/* inc/ea_pkg.sv */
package ea_pkg;
   // ---------------------------------------------------------------
   // addressing modes and operand sizes
   // ---------------------------------------------------------------
   typedef enum logic [3:0]
   {
      MODE_DIRECT,
      MODE_INDIRECT,
      MODE_POST_INC,
      MODE_PRE_DEC,
      MODE_DISP4,
      MODE_INDEXED,
      MODE_GLOBAL_DISP8,
      MODE_GLOBAL_INDEXED,
      MODE_PC_DISP8,
      MODE_IMM8
   } addr_mode_t;

   typedef enum logic [1:0]
   {
      SIZE_BYTE,
      SIZE_WORD,
      SIZE_LONG
   } op_size_t;

   // flag and branch operations
   typedef enum logic [2:0]
   {
      FLAG_KEEP,
      FLAG_SIGNED_GE,
      FLAG_EQUAL_REG,
      FLAG_EQUAL_IMM
   } flag_op_t;

   typedef enum logic [1:0]
   {
      BR_NONE,
      BR_IF_TRUE,
      BR_IF_FALSE
   } branch_op_t;

   localparam int DATA_W = 32;
   localparam logic FLAG_RESET = 1'b0;
   localparam logic [31:0] LONG_PC_MASK = 32'hFFFF_FFFC;
   localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
   localparam logic [31:0] STEP_WORD = 32'h0000_0002;
   localparam logic [31:0] STEP_LONG = 32'h0000_0004;
endpackage : ea_pkg

/* core/cpu_effective_address_unit.sv */
// Functional notes
// - signed compare sets flag; branches follow flag
// - add keeps flag; equal-immediate compare sets it
// - byte immediates come from instruction field
// - wide immediates load via PC-relative literal
// - absolute address: load constant, then indirect
// - long displacement: load index, then indexed
// - direct mode yields register, no address
// - indirect address is register, unmodified
// - post-increment by 1/2/4 after access
// - pre-decrement by 1/2/4, used as address
// - 4-bit zero-extended displacement scaled by size
// - indexed address is register plus index zero
// - 8-bit global-base displacement scaled, added
// - PC literal: word pc+2d, long masked+4d
// - logic immediates zero-extend, arithmetic sign-extend
// - byte/word loads sign-extend to 32 bits
// - misaligned word/long access raises address error
module cpu_effective_address_unit
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic op_valid,
   input wire ea_pkg::addr_mode_t mode,
   input wire ea_pkg::op_size_t op_size,
   input wire logic [31:0] selected_general_register,
   input wire logic [31:0] index_register_zero,
   input wire logic [31:0] global_base_register,
   input wire logic [31:0] pc_value,
   input wire logic [7:0] disp_field,
   input wire logic [7:0] imm_field,
   input wire logic imm_zero_ext,
   input wire ea_pkg::flag_op_t flag_op,
   input wire logic [31:0] compare_operand,
   input wire ea_pkg::branch_op_t branch_op,
   input wire logic load_valid,
   input wire ea_pkg::op_size_t load_size,
   input wire logic [31:0] load_raw,
   output logic mem_access,
   output logic [31:0] eff_addr,
   output logic [31:0] operand_value,
   output logic reg_wb_en,
   output logic [31:0] reg_wb_value,
   output logic address_error,
   output logic cond_flag,
   output logic branch_taken,
   output logic [31:0] load_result
);
   import ea_pkg::*;

   // ---------------------------------------------------------------
   // combinational address generation
   // ---------------------------------------------------------------
   logic [31:0] step;
   logic [31:0] disp4_scaled;
   logic [31:0] disp8_scaled;
   logic [31:0] imm_ext;
   logic [31:0] dec_value;
   logic [31:0] addr_c;
   logic [31:0] oper_c;
   logic mem_c;
   logic wb_c;
   logic [31:0] wb_val_c;
   logic misalign_c;

   // one size decode feeds every step and the 4/8-bit displacement scales; the PC literal scales on its own
   always_comb
   begin
      case (op_size)
         SIZE_BYTE: step = STEP_BYTE;
         SIZE_WORD: step = STEP_WORD;
         SIZE_LONG: step = STEP_LONG;
         default: step = STEP_BYTE;
      endcase
      disp4_scaled = 32'({28'h0, disp_field[3:0]} * step);
      disp8_scaled = 32'({24'h0, disp_field} * step);
      imm_ext = imm_zero_ext ? {24'h0, imm_field}
                             : {{24{imm_field[7]}}, imm_field};
      dec_value = selected_general_register - step;
   end

   // mode decode: address, operand and register writeback
   always_comb
   begin
      addr_c = 32'h0;
      oper_c = 32'h0;
      mem_c = 1'b1;
      wb_c = 1'b0;
      wb_val_c = 32'h0;
      case (mode)
         MODE_DIRECT:
         begin
            oper_c = selected_general_register;
            mem_c = 1'b0;
         end
         MODE_INDIRECT: addr_c = selected_general_register;
         MODE_POST_INC:
         begin
            addr_c = selected_general_register;
            wb_c = 1'b1;
            wb_val_c = selected_general_register + step;
         end
         MODE_PRE_DEC:
         begin
            addr_c = dec_value;
            wb_c = 1'b1;
            wb_val_c = dec_value;
         end
         MODE_DISP4: addr_c = selected_general_register + disp4_scaled;
         MODE_INDEXED: addr_c = selected_general_register + index_register_zero;
         MODE_GLOBAL_DISP8: addr_c = global_base_register + disp8_scaled;
         MODE_GLOBAL_INDEXED: addr_c = global_base_register + index_register_zero;
         MODE_PC_DISP8:
         begin
            // literal table fetch for wide immediates and address constants
            if (op_size == SIZE_LONG)
               addr_c = (pc_value & LONG_PC_MASK) + {22'h0, disp_field, 2'b00};
            else
               addr_c = pc_value + {23'h0, disp_field, 1'b0};
         end
         MODE_IMM8:
         begin
            oper_c = imm_ext;
            mem_c = 1'b0;
         end
         default: mem_c = 1'b0;
      endcase
      case (op_size)
         SIZE_WORD: misalign_c = mem_c & addr_c[0];
         SIZE_LONG: misalign_c = mem_c & (addr_c[1:0] != 2'b00);
         default: misalign_c = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------------
   logic mem_reg, mem_next;
   logic [31:0] addr_reg, addr_next;
   logic [31:0] oper_reg, oper_next;
   logic wb_reg, wb_next;
   logic [31:0] wb_val_reg, wb_val_next;
   logic err_reg, err_next;
   logic flag_reg, flag_next;
   logic br_reg, br_next;
   logic [31:0] load_reg, load_next;

   // flag updates only on compares; a branch sees the flag as it stood
   always_comb
   begin
      mem_next = op_valid & mem_c;
      addr_next = op_valid ? addr_c : addr_reg;
      oper_next = op_valid ? oper_c : oper_reg;
      wb_next = op_valid & wb_c;
      wb_val_next = op_valid ? wb_val_c : wb_val_reg;
      err_next = op_valid & misalign_c;
      flag_next = flag_reg;
      br_next = 1'b0;
      if (op_valid)
      begin
         case (flag_op)
            FLAG_SIGNED_GE:
               flag_next = $signed(selected_general_register) >=
                           $signed(compare_operand);
            FLAG_EQUAL_REG: flag_next = selected_general_register == compare_operand;
            FLAG_EQUAL_IMM: flag_next = selected_general_register == imm_ext;
            default: flag_next = flag_reg;
         endcase
         case (branch_op)
            BR_IF_TRUE: br_next = flag_reg;
            BR_IF_FALSE: br_next = ~flag_reg;
            default: br_next = 1'b0;
         endcase
      end
      load_next = load_reg;
      if (load_valid)
      begin
         case (load_size)
            SIZE_BYTE: load_next = {{24{load_raw[7]}}, load_raw[7:0]};
            SIZE_WORD: load_next = {{16{load_raw[15]}}, load_raw[15:0]};
            default: load_next = load_raw;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         mem_reg <= 1'b0;
         addr_reg <= 32'h0;
         oper_reg <= 32'h0;
         wb_reg <= 1'b0;
         wb_val_reg <= 32'h0;
         err_reg <= 1'b0;
         flag_reg <= FLAG_RESET;
         br_reg <= 1'b0;
         load_reg <= 32'h0;
      end
      else
      begin
         mem_reg <= mem_next;
         addr_reg <= addr_next;
         oper_reg <= oper_next;
         wb_reg <= wb_next;
         wb_val_reg <= wb_val_next;
         err_reg <= err_next;
         flag_reg <= flag_next;
         br_reg <= br_next;
         load_reg <= load_next;
      end
   end

   assign mem_access = mem_reg;
   assign eff_addr = addr_reg;
   assign operand_value = oper_reg;
   assign reg_wb_en = wb_reg;
   assign reg_wb_value = wb_val_reg;
   assign address_error = err_reg;
   assign cond_flag = flag_reg;
   assign branch_taken = br_reg;
   assign load_result = load_reg;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   ge_flag_a: assert property (@(posedge core_clk) disable iff (!resetn)
      op_valid && flag_op == FLAG_SIGNED_GE |=> cond_flag ==
      ($signed($past(selected_general_register)) >= $signed($past(compare_operand))))
      else $error("signed compare flag wrong");
   keep_flag_a: assert property (@(posedge core_clk) disable iff (!resetn)
      !op_valid || flag_op == FLAG_KEEP |=> $stable(cond_flag))
      else $error("flag changed without compare");
   branch_follow_a: assert property (@(posedge core_clk) disable iff (!resetn)
      op_valid && branch_op == BR_IF_TRUE |=> branch_taken == $past(cond_flag))
      else $error("branch if true wrong");
   post_inc_a: assert property (@(posedge core_clk) disable iff (!resetn)
      op_valid && mode == MODE_POST_INC && op_size == SIZE_LONG |=>
      reg_wb_en && reg_wb_value == eff_addr + 32'h4)
      else $error("post increment step wrong");
   pre_dec_a: assert property (@(posedge core_clk) disable iff (!resetn)
      op_valid && mode == MODE_PRE_DEC |=> reg_wb_en && reg_wb_value == eff_addr &&
      eff_addr == $past(selected_general_register) - (32'h1 << $past(op_size)))
      else $error("pre decrement address wrong");
   indexed_sum_a: assert property (@(posedge core_clk) disable iff (!resetn)
      op_valid && mode == MODE_INDEXED |=>
      eff_addr == $past(selected_general_register) + $past(index_register_zero))
      else $error("indexed address wrong");
   direct_nomem_a: assert property (@(posedge core_clk) disable iff (!resetn)
      op_valid && mode == MODE_DIRECT |=> !mem_access && !address_error)
      else $error("direct mode made an access");
   align_err_a: assert property (@(posedge core_clk) disable iff (!resetn)
      mem_access && eff_addr[0] && $past(op_size) == SIZE_WORD |-> address_error)
      else $error("misaligned word not flagged");
   pc_long_a: assert property (@(posedge core_clk) disable iff (!resetn)
      op_valid && mode == MODE_PC_DISP8 && op_size == SIZE_LONG |=> eff_addr[1:0] == 2'b00)
      else $error("long literal address unaligned");
endmodule : cpu_effective_address_unit

/* testbench/lsu_model.sv */
module lsu_model
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic mem_access,
   input wire logic [31:0] eff_addr,
   input wire logic address_error,
   output logic load_valid,
   output logic [31:0] load_raw
);
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------------------------------------------------------
   // memory side
   // ---------------------------------------------------------------
   // a clean access returns the inverted address one cycle later
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         load_valid <= 1'b0;
         load_raw <= 32'h5A5A_A5A5;
      end
      else
      begin
         load_valid <= mem_access & ~address_error;
         // idle bus keeps toggling so stale data cannot pass
         load_raw <= mem_access ? ~eff_addr : ~load_raw;
      end
   end
endmodule : lsu_model

/* testbench/cpu_effective_address_unit_test.sv */
`define CHK(a, b) \
   begin comparisons++; if ((a) !== (b)) begin failures++; \
   $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module cpu_effective_address_unit_test;
   timeunit 1ns;
   timeprecision 1ns;
   import ea_pkg::*;
   logic core_clk, resetn, op_valid, imm_zero_ext, load_valid, mem_access;
   logic reg_wb_en, address_error, cond_flag, branch_taken;
   addr_mode_t mode;
   op_size_t op_size, load_size;
   flag_op_t flag_op;
   branch_op_t branch_op;
   logic [31:0] selected_general_register, index_register_zero, global_base_register;
   logic [31:0] pc_value, compare_operand, load_raw, eff_addr, operand_value;
   logic [31:0] reg_wb_value, load_result, v;
   logic [7:0] disp_field, imm_field;
   logic [31:0] steps [3] = '{STEP_BYTE, STEP_WORD, STEP_LONG};
   int failures, comparisons;
   cpu_effective_address_unit dut (.*);
   lsu_model lsu (.*);
   // ---------------------------------------------------------------
   // shared driving
   // ---------------------------------------------------------------
   // one operation, then an idle cycle; outputs settle 1 ns after
   task automatic op(addr_mode_t m, op_size_t s, logic [31:0] r, logic [7:0] d,
      logic z, flag_op_t f, branch_op_t b, logic [31:0] c);
      @(posedge core_clk);
      op_valid <= 1'b1;
      mode <= m;
      op_size <= s;
      load_size <= s;
      selected_general_register <= r;
      disp_field <= d;
      imm_field <= d;
      imm_zero_ext <= z;
      flag_op <= f;
      branch_op <= b;
      compare_operand <= c;
      @(posedge core_clk);
      op_valid <= 1'b0;
      #1;
   endtask : op
   task automatic t_step;
      for (int i = 0; i < 3; i++)
      begin
         op(MODE_POST_INC, op_size_t'(i), 32'h1000_0000, 8'h00, 0, FLAG_KEEP, BR_NONE, 0);
         `CHK(eff_addr, 32'h1000_0000)
         `CHK({reg_wb_en, reg_wb_value}, {1'b1, 32'h1000_0000 + steps[i]})
         op(MODE_PRE_DEC, op_size_t'(i), 32'h1000_0000, 8'h00, 0, FLAG_KEEP, BR_NONE, 0);
         `CHK(eff_addr, 32'h1000_0000 - steps[i])
         `CHK({reg_wb_en, reg_wb_value}, {1'b1, 32'h1000_0000 - steps[i]})
      end
      op(MODE_POST_INC, SIZE_LONG, 32'hFFFF_FFFC, 8'h00, 0, FLAG_KEEP, BR_NONE, 0);
      `CHK(reg_wb_value, 32'h0000_0000)
   endtask : t_step
   task automatic t_disp;
      for (int i = 0; i < 3; i++)
      begin
         // upper nibble set to prove only four bits are used
         op(MODE_DISP4, op_size_t'(i), 32'h0000_4000, 8'hF7, 0, FLAG_KEEP, BR_NONE, 0);
         `CHK(eff_addr, 32'h0000_4000 + 32'h7 * steps[i])
         op(MODE_GLOBAL_DISP8, op_size_t'(i), 32'h0, 8'hF7, 0, FLAG_KEEP, BR_NONE, 0);
         `CHK(eff_addr, 32'h0000_2000 + 32'hF7 * steps[i])
      end
      op(MODE_INDEXED, SIZE_LONG, 32'hFFFF_FF00, 8'h00, 0, FLAG_KEEP, BR_NONE, 0);
      `CHK(eff_addr, 32'h0000_0000)
      op(MODE_GLOBAL_INDEXED, SIZE_LONG, 32'h0, 8'h00, 0, FLAG_KEEP, BR_NONE, 0);
      `CHK(eff_addr, 32'h0000_2100)
      op(MODE_INDIRECT, SIZE_WORD, 32'h0000_5552, 8'h00, 0, FLAG_KEEP, BR_NONE, 0);
      `CHK({mem_access, reg_wb_en, eff_addr}, {2'b10, 32'h0000_5552})
      op(MODE_PC_DISP8, SIZE_WORD, 32'h0, 8'hF7, 0, FLAG_KEEP, BR_NONE, 0);
      `CHK(eff_addr, 32'h0000_1006 + 32'h1EE)
      op(MODE_PC_DISP8, SIZE_LONG, 32'h0, 8'hF7, 0, FLAG_KEEP, BR_NONE, 0);
      `CHK(eff_addr, 32'h0000_1004 + 32'h3DC)
   endtask : t_disp
   task automatic t_imm;
      op(MODE_DIRECT, SIZE_LONG, 32'hCAFE_0001, 8'h00, 0, FLAG_KEEP, BR_NONE, 0);
      `CHK({mem_access, operand_value}, {1'b0, 32'hCAFE_0001})
      op(MODE_IMM8, SIZE_BYTE, 32'h0, 8'h85, 0, FLAG_KEEP, BR_NONE, 0);
      `CHK({mem_access, operand_value}, {1'b0, 32'hFFFF_FF85})
      op(MODE_IMM8, SIZE_BYTE, 32'h0, 8'h85, 1, FLAG_KEEP, BR_NONE, 0);
      `CHK(operand_value, 32'h0000_0085)
   endtask : t_imm
   task automatic t_align;
      op(MODE_INDIRECT, SIZE_WORD, 32'h0000_0101, 8'h00, 0, FLAG_KEEP, BR_NONE, 0);
      `CHK(address_error, 1'b1)
      op(MODE_INDIRECT, SIZE_LONG, 32'h0000_0102, 8'h00, 0, FLAG_KEEP, BR_NONE, 0);
      `CHK(address_error, 1'b1)
      op(MODE_INDIRECT, SIZE_BYTE, 32'h0000_0101, 8'h00, 0, FLAG_KEEP, BR_NONE, 0);
      `CHK({mem_access, address_error}, 2'b10)
   endtask : t_align
   task automatic t_load;
      for (int i = 0; i < 3; i++)
      begin
         op(MODE_INDIRECT, op_size_t'(i), 32'h1234_0070, 8'h00, 0, FLAG_KEEP, BR_NONE, 0);
         repeat (2) @(posedge core_clk);
         #1;
         v = ~32'h1234_0070;
         v = (i == 0) ? {{24{v[7]}}, v[7:0]} : (i == 1) ? {{16{v[15]}}, v[15:0]} : v;
         `CHK(load_result, v)
      end
   endtask : t_load
   task automatic t_flag;
      op(MODE_DIRECT, SIZE_LONG, 32'hFFFF_FFFF, 8'h00, 0, FLAG_SIGNED_GE, BR_NONE, 1);
      `CHK(cond_flag, 1'b0)
      op(MODE_DIRECT, SIZE_LONG, 0, 8'h00, 0, FLAG_KEEP, BR_IF_FALSE, 0);
      `CHK(branch_taken, 1'b1)
      op(MODE_DIRECT, SIZE_LONG, 32'h5, 8'h00, 0, FLAG_SIGNED_GE, BR_NONE, 32'h5);
      op(MODE_DIRECT, SIZE_LONG, 0, 8'h00, 0, FLAG_KEEP, BR_IF_TRUE, 0);
      `CHK({cond_flag, branch_taken}, 2'b11)
      op(MODE_DIRECT, SIZE_LONG, 0, 8'h00, 0, FLAG_KEEP, BR_IF_FALSE, 0);
      `CHK({cond_flag, branch_taken}, 2'b10)
      op(MODE_IMM8, SIZE_BYTE, 32'h1, 8'h00, 0, FLAG_EQUAL_IMM, BR_NONE, 0);
      `CHK(cond_flag, 1'b0)
      op(MODE_IMM8, SIZE_BYTE, 32'hFFFF_FFFF, 8'hFF, 0, FLAG_EQUAL_IMM, BR_NONE, 0);
      `CHK(cond_flag, 1'b1)
      // register compare must clear a flag that stands set
      op(MODE_DIRECT, SIZE_LONG, 32'h7, 8'h00, 0, FLAG_EQUAL_REG, BR_NONE, 32'h8);
      `CHK(cond_flag, 1'b0)
      op(MODE_DIRECT, SIZE_LONG, 32'h7, 8'h00, 0, FLAG_EQUAL_REG, BR_NONE, 32'h7);
      `CHK(cond_flag, 1'b1)
   endtask : t_flag
   // reset in mid-run must clear the flag and every registered output except reg_wb_value
   task automatic t_reset;
      @(posedge core_clk);
      resetn <= 1'b0;
      @(posedge core_clk);
      #1;
      `CHK({cond_flag, branch_taken, reg_wb_en, address_error, mem_access}, 5'h00)
      `CHK({eff_addr, load_result}, 64'h0)
      @(posedge core_clk);
      resetn <= 1'b1;
      #1;
      `CHK({cond_flag, eff_addr, operand_value}, 65'h0)
      op(MODE_INDIRECT, SIZE_LONG, 32'h0000_0400, 8'h00, 0, FLAG_KEEP, BR_NONE, 0);
      `CHK({mem_access, eff_addr}, {1'b1, 32'h0000_0400})
   endtask : t_reset
   // ---------------------------------------------------------------
   // verdict
   // ---------------------------------------------------------------
   task automatic stop_test;
      if (failures == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test
   // clock at 100 ns period
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // watchdog well beyond the hundred or so cycles of the run
   initial
   begin
      #400000;
      failures++;
      stop_test();
   end
   initial
   begin
      {resetn, op_valid, imm_zero_ext, disp_field, imm_field} = '0;
      mode = MODE_DIRECT;
      op_size = SIZE_BYTE;
      load_size = SIZE_BYTE;
      flag_op = FLAG_KEEP;
      branch_op = BR_NONE;
      {selected_general_register, compare_operand} = '0;
      index_register_zero = 32'h0000_0100;
      global_base_register = 32'h0000_2000;
      pc_value = 32'h0000_1006;
      repeat (10) @(posedge core_clk);
      resetn <= 1'b1;
      #1;
      `CHK({cond_flag, mem_access, eff_addr}, 34'h0)
      t_step();
      t_disp();
      t_imm();
      t_align();
      t_load();
      t_flag();
      t_reset();
      stop_test();
   end
endmodule : cpu_effective_address_unit_test
